// File: rtl/dbt_params.svh
// Contract
// R1 - A force request lets the current instruction finish first.
// R2 - A tag request rides with its opcode and acts only if it executes.
// R3 - With opcode select set, a match counts only if its opcode executes; inside and outside modes ignore it and trigger on raw addresses.
// R4 - Each comparator has its own opcode tracker.
// R5 - A four-bit trigger mode field picks one of nine trigger modes.
// R6 - Begin select picks store-after-trigger or circular until trigger.
// R7 - A launch write arms the run and clears both hit flags and the count.
// R8 - A begin-trace run ends on its own once the trace FIFO is full.
// R9 - An end-trace run ends on the trigger, keeping the history.
// R10 - Writing zero to launch or enable stops any run at once.
// R11 - Outside event-only modes the FIFO stores change-of-flow addresses.
// R12 - Event-only modes store the data byte in the low eight bits.
// R13 - Event-only modes ignore begin select and run as begin type.
// R14 - A match may be qualified by bus direction when enabled.
// R15 - With breakpoint enable set, a trigger requests a tag or force break; the code drives tags from comparator matches on opcode fetch.
// R16 - With no run armed, matches neither store nor set hit flags.
`ifndef DBT_PARAMS_SVH
`define DBT_PARAMS_SVH

// Register indices on the plain register port.
`define DBT_OFF_CMP_ONE 4'h0
`define DBT_OFF_CMP_TWO 4'h1
`define DBT_OFF_CTRL 4'h2
`define DBT_OFF_TRIG 4'h3
`define DBT_OFF_STATUS 4'h4
`define DBT_OFF_FIFO 4'h5
`define DBT_OFF_IRQ_STAT 4'h6
`define DBT_OFF_IRQ_MASK 4'h7

// Control register fields.
`define DBT_CTRL_ENABLE 7
`define DBT_CTRL_LAUNCH 6
`define DBT_CTRL_TAG 5
`define DBT_CTRL_BREAKPOINT_REQUEST_ENABLE 4
`define DBT_CTRL_DIR_VAL_ONE 3
`define DBT_CTRL_DIR_EN_ONE 2
`define DBT_CTRL_DIR_VAL_TWO 1
`define DBT_CTRL_DIR_EN_TWO 0

// Trigger config fields.
`define DBT_TRIG_OPSEL 7
`define DBT_TRIG_BEGIN 6

// Status register fields.
`define DBT_STAT_HIT_ONE 7
`define DBT_STAT_HIT_TWO 6
`define DBT_STAT_ARMED 5

// Interrupt status bits.
`define DBT_IRQ_TRIG 0
`define DBT_IRQ_END 1
`define DBT_IRQ_BRK 2

// Reset values and sizes.
`define DBT_RST_WORD 16'h0000
`define DBT_RST_CFG 8'h00
`define DBT_FIFO_DEPTH 8
`define DBT_TRACK_DEPTH 4

`endif

// File: rtl/dbt_pkg.sv
package dbt_pkg;
    // Trigger modes held in the trigger mode field.
    typedef enum logic [3:0] {
        MODE_A_ONLY,
        MODE_A_OR_B,
        MODE_A_THEN_B,
        MODE_EVENT_B,
        MODE_A_THEN_EVENT_B,
        MODE_A_AND_B_DATA,
        MODE_A_NOT_B_DATA,
        MODE_INSIDE,
        MODE_OUTSIDE
    } dbt_mode_t;

    // Run phases of the debug controller.
    typedef enum logic [1:0] {
        RUN_IDLE,
        RUN_WAIT,
        RUN_CAP
    } dbt_run_t;
endpackage : dbt_pkg

// File: rtl/dbt_fifo_if.sv
`timescale 1ns/1ps
`default_nettype none
// Trace store handshake between the run controller and the FIFO.
interface dbt_fifo_if;
    logic push;
    logic [15:0] pdata;
    logic circ;
    logic clr;
    logic pop;
    logic [15:0] head;
    logic full;
    logic empty;
    logic [3:0] count;
    modport ctl (output push, pdata, circ, clr, pop,
                 input head, full, empty, count);
    modport store (input push, pdata, circ, clr, pop,
                   output head, full, empty, count);
endinterface : dbt_fifo_if
`default_nettype wire

// File: rtl/dbt_op_track.sv
`timescale 1ns/1ps
`default_nettype none
`include "dbt_params.svh"
module dbt_op_track
    import dbt_pkg::*;
(
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Instruction queue activity.
    input wire logic fetch_i,
    input wire logic tag_i,
    input wire logic exec_i,
    input wire logic flush_i,
    // Tracked match for the executing opcode.
    output logic hit_o
);
    logic [`DBT_TRACK_DEPTH-1:0] tags_r, tags_nxt;
    logic [2:0] cnt_r, cnt_nxt;
    logic pop;

    // A tag leaves the queue when its own opcode executes, or when a flush drops the queue.
    assign pop = exec_i && (cnt_r != 3'h0);
    assign hit_o = pop && tags_r[0];

    // Pop first, then push behind the survivors.
    always_comb begin
        tags_nxt = pop ? (tags_r >> 1) : tags_r;
        cnt_nxt = pop ? cnt_r - 3'h1 : cnt_r;
        if (fetch_i && (cnt_nxt < 3'(`DBT_TRACK_DEPTH))) begin
            tags_nxt[cnt_nxt[1:0]] = tag_i;
            cnt_nxt = cnt_nxt + 3'h1;
        end
    end

    // A queue flush drops every pending tag with its opcode.
    always_ff @(posedge clk_i) begin
        if (rst_i || flush_i) begin
            tags_r <= '0;
            cnt_r <= 3'h0;
        end else begin
            tags_r <= tags_nxt;
            cnt_r <= cnt_nxt;
        end
    end
endmodule : dbt_op_track
`default_nettype wire

// File: rtl/dbt_trace_fifo.sv
`timescale 1ns/1ps
`default_nettype none
`include "dbt_params.svh"
module dbt_trace_fifo
    import dbt_pkg::*;
(
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Controller side.
    dbt_fifo_if.store f
);
    logic [15:0] mem_r [`DBT_FIFO_DEPTH];
    logic [2:0] wr_r;
    logic [2:0] rd_r;
    logic [3:0] cnt_r;
    logic do_pop, do_push, drop_old;

    assign f.full = (cnt_r == 4'(`DBT_FIFO_DEPTH));
    assign f.empty = (cnt_r == 4'h0);
    assign f.count = cnt_r;
    assign f.head = mem_r[rd_r];
    assign do_pop = f.pop && !f.empty;
    // In circular mode a full store overwrites its oldest entry.
    assign drop_old = f.push && f.full && f.circ && !do_pop;
    assign do_push = f.push && (!f.full || f.circ || do_pop);

    // Storage write.
    always_ff @(posedge clk_i) begin
        if (do_push) begin
            mem_r[wr_r] <= f.pdata;
        end
    end

    // Pointers and fill count.
    always_ff @(posedge clk_i) begin
        if (rst_i || f.clr) begin
            wr_r <= 3'h0;
            rd_r <= 3'h0;
            cnt_r <= 4'h0;
        end else begin
            if (do_push) begin
                wr_r <= wr_r + 3'h1;
            end
            if (do_pop || drop_old) begin
                rd_r <= rd_r + 3'h1;
            end
            if (do_push && !do_pop && !drop_old) begin
                cnt_r <= cnt_r + 4'h1;
            end else if (do_pop && !do_push) begin
                cnt_r <= cnt_r - 4'h1;
            end
        end
    end
endmodule : dbt_trace_fifo
`default_nettype wire

// File: rtl/dbt_debug_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "dbt_params.svh"
module dbt_debug_top
    import dbt_pkg::*;
(
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Register port.
    input wire logic [3:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [15:0] reg_rdata_o,
    // Monitored CPU bus cycle.
    input wire logic bus_valid_i,
    input wire logic [15:0] bus_addr_i,
    input wire logic [7:0] bus_data_i,
    input wire logic bus_rw_i,
    input wire logic bus_opfetch_i,
    // Instruction queue and change of flow.
    input wire logic q_exec_i,
    input wire logic q_flush_i,
    input wire logic cof_valid_i,
    input wire logic [15:0] cof_addr_i,
    // Breakpoint requests to the core.
    input wire logic bg_entered_i,
    output logic brk_tag_o,
    output logic brk_force_o,
    // Interrupt.
    output logic irq_o
);
    logic [15:0] cmp_one_r;
    logic [15:0] cmp_two_r;
    logic [7:0] ctrl_r;
    logic [7:0] trig_cfg_r;
    logic [2:0] irq_stat_r;
    logic [2:0] irq_mask_r;
    logic [15:0] rdata_r;
    logic hit_one_r, hit_two_r, a_seen_r, force_r;
    dbt_run_t run_r, run_nxt;
    dbt_mode_t mode;
    logic ctrl_wr, launch, stop, armed, event_only, begin_eff;
    logic match_one, match_two, fetch_one;
    logic trk_one, trk_two, qual_one, qual_two;
    logic in_range, data_eq, trig, store_evt, run_end;
    logic [2:0] irq_set;

    dbt_fifo_if fif ();

    // Address compare with optional direction qualify.
    function automatic logic cmp_match(input logic [15:0] addr,
                                       input logic [15:0] ref_addr,
                                       input logic dir_en,
                                       input logic dir_val,
                                       input logic rw);
        cmp_match = (addr == ref_addr) && (!dir_en || (rw == dir_val));
    endfunction : cmp_match

    // Modes that store bus data rather than addresses.
    function automatic logic is_event_only(input dbt_mode_t m);
        is_event_only = (m == MODE_EVENT_B) || (m == MODE_A_THEN_EVENT_B);
    endfunction : is_event_only

    // R5 mode field decode.
    assign mode = dbt_mode_t'(trig_cfg_r[3:0]);
    assign event_only = is_event_only(mode);
    // R13 event-only runs are begin type.
    assign begin_eff = trig_cfg_r[`DBT_TRIG_BEGIN] || event_only;
    assign armed = (run_r != RUN_IDLE);

    // Control writes either launch a run or stop it.
    assign ctrl_wr = reg_wr_i && (reg_addr_i == `DBT_OFF_CTRL);
    // R7 launch on write.
    assign launch = ctrl_wr && reg_wdata_i[`DBT_CTRL_LAUNCH]
                    && reg_wdata_i[`DBT_CTRL_ENABLE];
    // R10 manual stop.
    assign stop = ctrl_wr && !launch;

    // R14 direction qualify per comparator.
    assign match_one = bus_valid_i && cmp_match(bus_addr_i, cmp_one_r,
        ctrl_r[`DBT_CTRL_DIR_EN_ONE], ctrl_r[`DBT_CTRL_DIR_VAL_ONE],
        bus_rw_i);
    assign match_two = bus_valid_i && cmp_match(bus_addr_i, cmp_two_r,
        ctrl_r[`DBT_CTRL_DIR_EN_TWO], ctrl_r[`DBT_CTRL_DIR_VAL_TWO],
        bus_rw_i);
    assign fetch_one = bus_valid_i && bus_opfetch_i;

    // R4 one tracker per comparator.
    dbt_op_track u_track_one (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .fetch_i(fetch_one),
        .tag_i(match_one),
        .exec_i(q_exec_i),
        .flush_i(q_flush_i),
        .hit_o(trk_one)
    );

    dbt_op_track u_track_two (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .fetch_i(fetch_one),
        .tag_i(match_two),
        .exec_i(q_exec_i),
        .flush_i(q_flush_i),
        .hit_o(trk_two)
    );

    // R3 tracked trigger.
    assign qual_one = trig_cfg_r[`DBT_TRIG_OPSEL] ? trk_one : match_one;
    assign qual_two = trig_cfg_r[`DBT_TRIG_OPSEL] ? trk_two : match_two;

    // Range and full-mode helpers use raw bus values.
    assign in_range = (bus_addr_i >= cmp_one_r) && (bus_addr_i <= cmp_two_r);
    assign data_eq = (bus_data_i == cmp_two_r[7:0]);

    // R5 trigger per mode.
    always_comb begin
        case (mode)
            MODE_A_ONLY: trig = qual_one;
            MODE_A_OR_B: trig = qual_one || qual_two;
            MODE_A_THEN_B: trig = a_seen_r && qual_two;
            MODE_EVENT_B: trig = qual_two;
            MODE_A_THEN_EVENT_B: trig = a_seen_r && qual_two;
            MODE_A_AND_B_DATA: trig = qual_one && data_eq;
            MODE_A_NOT_B_DATA: trig = qual_one && !data_eq;
            MODE_INSIDE: trig = bus_valid_i && in_range;
            MODE_OUTSIDE: trig = bus_valid_i && !in_range;
            default: trig = 1'b0;
        endcase
    end

    // Run phase sequencing.
    always_comb begin
        run_nxt = run_r;
        case (run_r)
            RUN_IDLE: run_nxt = RUN_IDLE;
            RUN_WAIT: begin
                if (trig) begin
                    run_nxt = RUN_CAP;
                end
            end
            RUN_CAP: begin
                // R8 begin run ends on full.
                if (begin_eff && fif.full) begin
                    run_nxt = RUN_IDLE;
                // R9 end run ends on trigger.
                end else if (!begin_eff && trig) begin
                    run_nxt = RUN_IDLE;
                end
            end
            default: run_nxt = RUN_IDLE;
        endcase
        // R6 begin waits, end captures at once.
        if (launch) begin
            run_nxt = begin_eff ? RUN_WAIT : RUN_CAP;
        // R10 stop wins over the run.
        end else if (stop) begin
            run_nxt = RUN_IDLE;
        end
    end

    assign run_end = armed && (run_nxt == RUN_IDLE) && !stop;

    // Run phase register.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            run_r <= RUN_IDLE;
        end else begin
            run_r <= run_nxt;
        end
    end

    // R16 hit flags move only while armed.
    always_ff @(posedge clk_i) begin
        if (rst_i || launch) begin
            hit_one_r <= 1'b0;
            hit_two_r <= 1'b0;
            a_seen_r <= 1'b0;
        end else if (armed) begin
            hit_one_r <= hit_one_r || qual_one;
            hit_two_r <= hit_two_r || qual_two;
            a_seen_r <= a_seen_r || qual_one;
        end
    end

    // Event capture needs comparator two; only A-then-event-B mode also needs an earlier A match.
    assign store_evt = qual_two
                       && ((mode == MODE_EVENT_B) || a_seen_r);

    // R11 change-of-flow capture.
    // R12 data byte in event modes.
    always_comb begin
        fif.push = 1'b0;
        fif.pdata = cof_addr_i;
        if (run_r == RUN_CAP) begin
            fif.push = event_only ? store_evt : cof_valid_i;
        end
        if (event_only) begin
            fif.pdata = {8'h00, bus_data_i};
        end
    end

    // R6 circular store in end-trace.
    assign fif.circ = !begin_eff;
    // R7 launch empties the FIFO.
    assign fif.clr = launch;
    assign fif.pop = reg_rd_i && (reg_addr_i == `DBT_OFF_FIFO);

    dbt_trace_fifo u_fifo (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .f(fif)
    );

    // R2 tag rides with the fetch.
    // R15 request type from the tag bit.
    assign brk_tag_o = armed && ctrl_r[`DBT_CTRL_BREAKPOINT_REQUEST_ENABLE]
                       && ctrl_r[`DBT_CTRL_TAG] && bus_valid_i
                       && bus_opfetch_i && (match_one || match_two);
    assign brk_force_o = force_r;

    // R1 force held until the core enters background; set wins.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            force_r <= 1'b0;
        end else if (armed && ctrl_r[`DBT_CTRL_BREAKPOINT_REQUEST_ENABLE]
                     && !ctrl_r[`DBT_CTRL_TAG] && trig) begin
            force_r <= 1'b1;
        end else if (bg_entered_i) begin
            force_r <= 1'b0;
        end
    end

    // Configuration registers written by software.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cmp_one_r <= `DBT_RST_WORD;
            cmp_two_r <= `DBT_RST_WORD;
            ctrl_r <= `DBT_RST_CFG;
            trig_cfg_r <= `DBT_RST_CFG;
            irq_mask_r <= 3'h0;
        end else if (reg_wr_i) begin
            case (reg_addr_i)
                `DBT_OFF_CMP_ONE: cmp_one_r <= reg_wdata_i;
                `DBT_OFF_CMP_TWO: cmp_two_r <= reg_wdata_i;
                `DBT_OFF_CTRL: ctrl_r <= reg_wdata_i[7:0];
                `DBT_OFF_TRIG: trig_cfg_r <= reg_wdata_i[7:0];
                `DBT_OFF_IRQ_MASK: irq_mask_r <= reg_wdata_i[2:0];
                default: ;
            endcase
        end
    end

    // Launch reads back as armed, so it drops at run end.
    // Interrupt events; a new event beats a write-one clear.
    assign irq_set[`DBT_IRQ_TRIG] = armed && trig;
    assign irq_set[`DBT_IRQ_END] = run_end;
    assign irq_set[`DBT_IRQ_BRK] = armed && ctrl_r[`DBT_CTRL_BREAKPOINT_REQUEST_ENABLE] && trig;

    // Sticky interrupt status.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat_r <= 3'h0;
        end else if (reg_wr_i && (reg_addr_i == `DBT_OFF_IRQ_STAT)) begin
            irq_stat_r <= (irq_stat_r & ~reg_wdata_i[2:0]) | irq_set;
        end else begin
            irq_stat_r <= irq_stat_r | irq_set;
        end
    end

    assign irq_o = |(irq_stat_r & irq_mask_r);

    // Read data stands in the cycle after the read strobe.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_r <= `DBT_RST_WORD;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                `DBT_OFF_CMP_ONE: rdata_r <= cmp_one_r;
                `DBT_OFF_CMP_TWO: rdata_r <= cmp_two_r;
                `DBT_OFF_CTRL: rdata_r <= {8'h00, ctrl_r[7],
                    armed, ctrl_r[5:0]};
                `DBT_OFF_TRIG: rdata_r <= {8'h00, trig_cfg_r};
                `DBT_OFF_STATUS: rdata_r <= {8'h00, hit_one_r, hit_two_r,
                    armed, 1'b0, fif.count};
                `DBT_OFF_FIFO: rdata_r <= fif.empty ? 16'h0000 : fif.head;
                `DBT_OFF_IRQ_STAT: rdata_r <= {13'h0000, irq_stat_r};
                `DBT_OFF_IRQ_MASK: rdata_r <= {13'h0000, irq_mask_r};
                default: rdata_r <= 16'h0000;
            endcase
        end else begin
            rdata_r <= 16'h0000;
        end
    end

    assign reg_rdata_o = rdata_r;
endmodule : dbt_debug_top
`default_nettype wire

// File: sim/dbt_debug_checker_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "dbt_params.svh"
module dbt_debug_checker (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Register port.
    input wire logic [3:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [15:0] reg_rdata_o,
    // Core side.
    input wire logic bus_valid_i,
    input wire logic bus_opfetch_i,
    input wire logic q_exec_i,
    input wire logic cof_valid_i,
    input wire logic bg_entered_i,
    input wire logic brk_tag_o,
    input wire logic brk_force_o,
    input wire logic irq_o
);
    logic [7:0] ctrl_r;
    logic [7:0] mask_r;
    logic quiet;
    // Shadows of control and mask, so outputs can be tied to them.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_r <= 8'h00;
            mask_r <= 8'h00;
        end else if (reg_wr_i && reg_addr_i == `DBT_OFF_CTRL) begin
            ctrl_r <= reg_wdata_i[7:0];
        end else if (reg_wr_i && reg_addr_i == `DBT_OFF_IRQ_MASK) begin
            mask_r <= reg_wdata_i[7:0];
        end
    end
    // No activity that could move the status.
    assign quiet = !(reg_wr_i || bus_valid_i || cof_valid_i || q_exec_i);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    chk_rdata_quiet: assert property (!$past(reg_rd_i)
        |-> reg_rdata_o == 16'h0000) else $error("read data not idle");
    chk_unmapped_zero: assert property (reg_rd_i && reg_addr_i[3]
        |=> reg_rdata_o == 16'h0000) else $error("unmapped read not zero");
    chk_launch_arms: assert property (
        reg_wr_i && reg_addr_i == `DBT_OFF_CTRL && reg_wdata_i[7:6] == 2'b11
        ##1 quiet ##1 reg_rd_i && reg_addr_i == `DBT_OFF_STATUS
        |=> reg_rdata_o[7:5] == 3'b001 && reg_rdata_o[3:0] == 4'h0)
        else $error("launch did not arm and clear");
    chk_stop_disarms: assert property (
        reg_wr_i && reg_addr_i == `DBT_OFF_CTRL && reg_wdata_i[7:6] != 2'b11
        ##1 quiet ##1 reg_rd_i && reg_addr_i == `DBT_OFF_STATUS
        |=> !reg_rdata_o[5]) else $error("stop left run armed");
    chk_tag_fetch: assert property (
        brk_tag_o |-> bus_valid_i && bus_opfetch_i)
        else $error("tag request outside opcode fetch");
    chk_tag_select: assert property (
        brk_tag_o |-> ctrl_r[7:4] == 4'hF)
        else $error("tag request not enabled");
    chk_force_select: assert property (
        $rose(brk_force_o) |-> $past(ctrl_r[7:4]) == 4'hD)
        else $error("force request not enabled");
    chk_force_hold: assert property (
        brk_force_o && !bg_entered_i |=> brk_force_o)
        else $error("force request dropped early");
    chk_irq_masked: assert property (mask_r == 8'h00 |-> !irq_o)
        else $error("interrupt while fully masked");

    cover property ($rose(brk_force_o));
    cover property (brk_tag_o);
    cover property ($rose(irq_o));
endmodule : dbt_debug_checker

bind dbt_debug_top dbt_debug_checker dbt_debug_checker_inst (.*);
`default_nettype wire

// File: sim/dbt_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module dbt_cpu_model #(
    parameter int FINISH_CYC = 3
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Requests from the debug block.
    input wire logic brk_tag_i,
    input wire logic brk_force_i,
    // Bus cycles.
    output logic bus_valid_o,
    output logic [15:0] bus_addr_o,
    output logic [7:0] bus_data_o,
    output logic bus_rw_o,
    output logic bus_opfetch_o,
    // Queue and flow events.
    output logic q_exec_o,
    output logic q_flush_o,
    output logic cof_valid_o,
    output logic [15:0] cof_addr_o,
    output logic bg_entered_o
);
    logic tag_seen;
    int fin_cnt;
    // Everything idle at time zero.
    initial begin
        {bus_valid_o, bus_addr_o, bus_data_o, bus_rw_o, bus_opfetch_o,
            q_exec_o, q_flush_o, cof_valid_o, cof_addr_o, bg_entered_o,
            tag_seen} = '0;
        fin_cnt = 0;
    end
    // One bus cycle; released address and data show the inverse value.
    task bus_cycle(input logic [15:0] a, input logic [7:0] d, input logic rw,
                   input logic op);
        @(posedge clk_i);
        bus_valid_o <= 1'b1;
        bus_addr_o <= a;
        bus_data_o <= d;
        bus_rw_o <= rw;
        bus_opfetch_o <= op;
        @(posedge clk_i);
        tag_seen = brk_tag_i;
        bus_valid_o <= 1'b0;
        bus_opfetch_o <= 1'b0;
        bus_addr_o <= ~a;
        bus_data_o <= ~d;
    endtask : bus_cycle
    // Oldest opcode executes, or the whole queue is flushed.
    task queue_step(input logic flush);
        @(posedge clk_i);
        q_exec_o <= !flush;
        q_flush_o <= flush;
        @(posedge clk_i);
        q_exec_o <= 1'b0;
        q_flush_o <= 1'b0;
    endtask : queue_step
    // One change-of-flow report.
    task flow(input logic [15:0] a);
        @(posedge clk_i);
        cof_valid_o <= 1'b1;
        cof_addr_o <= a;
        @(posedge clk_i);
        cof_valid_o <= 1'b0;
        cof_addr_o <= ~a;
    endtask : flow
    always @(posedge clk_i) begin
        if (rst_i || !brk_force_i || bg_entered_o) begin
            fin_cnt <= 0;
            bg_entered_o <= 1'b0;
        end else if (fin_cnt == FINISH_CYC) begin
            bg_entered_o <= 1'b1;
        end else begin
            fin_cnt <= fin_cnt + 1;
        end
    end
endmodule : dbt_cpu_model
`default_nettype wire

// File: sim/tb_dbt_debug_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "dbt_params.svh"
module tb_dbt_debug_top;
    logic clk_i, rst_i, reg_wr_i, reg_rd_i;
    logic [3:0] reg_addr_i;
    logic [15:0] reg_wdata_i, reg_rdata_o, bus_addr_i, cof_addr_i;
    logic [7:0] bus_data_i;
    logic bus_valid_i, bus_rw_i, bus_opfetch_i, q_exec_i, q_flush_i;
    logic cof_valid_i, bg_entered_i, brk_tag_o, brk_force_o, irq_o;
    int error_cnt = 0;
    int check_count = 0;
    // Free-running 200 MHz clock.
    always #2.5 clk_i = ~clk_i;
    dbt_debug_top dbt_debug_top_inst (.*);
    dbt_cpu_model dbt_cpu_model_inst (.clk_i, .rst_i, .brk_tag_i(brk_tag_o),
        .brk_force_i(brk_force_o), .bus_valid_o(bus_valid_i),
        .bus_addr_o(bus_addr_i), .bus_data_o(bus_data_i), .bus_rw_o(bus_rw_i),
        .bus_opfetch_o(bus_opfetch_i), .q_exec_o(q_exec_i),
        .q_flush_o(q_flush_i), .cof_valid_o(cof_valid_i),
        .cof_addr_o(cof_addr_i), .bg_entered_o(bg_entered_i));
    // Four-state compare so unknowns never pass.
    task chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: %h expected %h", $time, got, exp);
        end
    endtask : chk
    task chk1(input logic got, input logic exp);
        chk({15'h0000, got}, {15'h0000, exp});
    endtask : chk1
    task wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask : wr
    task rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        #1 chk(reg_rdata_o, exp);
    endtask : rd
    task bus(input logic [15:0] a, input logic [7:0] d, input logic rw,
             input logic op);
        dbt_cpu_model_inst.bus_cycle(a, d, rw, op);
    endtask : bus
    task t_reset;
        rd(`DBT_OFF_CTRL, 16'h0000);
        rd(`DBT_OFF_STATUS, 16'h0000);
        rd(`DBT_OFF_IRQ_STAT, 16'h0000);
        rd(`DBT_OFF_FIFO, 16'h0000);
        rd(4'hC, 16'h0000);
        $display("test reset done");
    endtask : t_reset
    task t_end;
        wr(`DBT_OFF_CMP_ONE, 16'h1234);
        wr(`DBT_OFF_TRIG, 16'h0000);
        wr(`DBT_OFF_CTRL, 16'h00C0);
        for (int i = 0; i < 3; i++) dbt_cpu_model_inst.flow(16'h0100 + 16'(i));
        bus(16'h1234, 8'h00, 1'b1, 1'b0);
        dbt_cpu_model_inst.flow(16'h0200);
        rd(`DBT_OFF_STATUS, 16'h0083);
        for (int i = 0; i < 3; i++) rd(`DBT_OFF_FIFO, 16'h0100 + 16'(i));
        rd(`DBT_OFF_IRQ_STAT, 16'h0003);
        wr(`DBT_OFF_IRQ_MASK, 16'h0002);
        #1 chk1(irq_o, 1'b1);
        wr(`DBT_OFF_IRQ_STAT, 16'h0002);
        #1 chk1(irq_o, 1'b0);
        wr(`DBT_OFF_IRQ_MASK, 16'h0000);
        $display("test end trace done");
    endtask : t_end
    task t_begin;
        wr(`DBT_OFF_TRIG, 16'h0040);
        wr(`DBT_OFF_CTRL, 16'h00C0);
        dbt_cpu_model_inst.flow(16'h0300);
        bus(16'h1234, 8'h00, 1'b1, 1'b0);
        for (int i = 0; i < 10; i++) dbt_cpu_model_inst.flow(16'h0400 + 16'(i));
        rd(`DBT_OFF_STATUS, 16'h0080 | 16'(`DBT_FIFO_DEPTH));
        rd(`DBT_OFF_FIFO, 16'h0400);
        $display("test begin trace done");
    endtask : t_begin
    task t_event;
        wr(`DBT_OFF_CMP_TWO, 16'h2000);
        wr(`DBT_OFF_TRIG, 16'h0003);
        wr(`DBT_OFF_CTRL, 16'h00C0);
        bus(16'h2000, 8'hA5, 1'b0, 1'b0);
        bus(16'h2000, 8'h5A, 1'b0, 1'b0);
        dbt_cpu_model_inst.flow(16'h0500);
        rd(`DBT_OFF_STATUS, 16'h0061);
        rd(`DBT_OFF_FIFO, 16'h005A);
        rd(`DBT_OFF_FIFO, 16'h0000);
        $display("test event done");
    endtask : t_event
    task t_dir;
        wr(`DBT_OFF_TRIG, 16'h0000);
        wr(`DBT_OFF_CTRL, 16'h00C4);
        rd(`DBT_OFF_STATUS, 16'h0020);
        bus(16'h1234, 8'h00, 1'b1, 1'b0);
        rd(`DBT_OFF_STATUS, 16'h0020);
        bus(16'h1234, 8'h00, 1'b0, 1'b0);
        rd(`DBT_OFF_STATUS, 16'h0080);
        $display("test direction done");
    endtask : t_dir
    task t_stop;
        for (int k = 0; k < 2; k++) begin
            wr(`DBT_OFF_CTRL, 16'h00C0);
            wr(`DBT_OFF_CTRL, k ? 16'h0040 : 16'h0080);
            rd(`DBT_OFF_STATUS, 16'h0000);
            dbt_cpu_model_inst.flow(16'h0600);
            bus(16'h1234, 8'h00, 1'b1, 1'b0);
            rd(`DBT_OFF_STATUS, 16'h0000);
        end
        $display("test stop done");
    endtask : t_stop
    task t_tag;
        wr(`DBT_OFF_CMP_ONE, 16'h3000);
        wr(`DBT_OFF_CMP_TWO, 16'h3002);
        wr(`DBT_OFF_TRIG, 16'h00C1);
        wr(`DBT_OFF_CTRL, 16'h00F0);
        bus(16'h3000, 8'h00, 1'b1, 1'b1);
        chk1(dbt_cpu_model_inst.tag_seen, 1'b1);
        dbt_cpu_model_inst.queue_step(1'b1);
        rd(`DBT_OFF_STATUS, 16'h0020);
        bus(16'h3000, 8'h00, 1'b1, 1'b1);
        bus(16'h3002, 8'h00, 1'b1, 1'b1);
        dbt_cpu_model_inst.queue_step(1'b0);
        dbt_cpu_model_inst.queue_step(1'b0);
        rd(`DBT_OFF_STATUS, 16'h00E0);
        $display("test tag done");
    endtask : t_tag
    task t_force;
        wr(`DBT_OFF_TRIG, 16'h0000);
        wr(`DBT_OFF_CTRL, 16'h00D0);
        bus(16'h3000, 8'h00, 1'b1, 1'b0);
        @(posedge clk_i);
        #1 chk1(brk_force_o, 1'b1);
        repeat (dbt_cpu_model_inst.FINISH_CYC) @(posedge clk_i);
        #1 chk1(bg_entered_i, 1'b1);
        chk1(brk_force_o, 1'b1);
        @(posedge clk_i);
        #1 chk1(brk_force_o, 1'b0);
        $display("test force done");
    endtask : t_force
    // Single exit point for both normal end and watchdog.
    task wrap_up;
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : wrap_up
    // Main sequence; stimulus starts at the first edge after reset.
    initial begin
        {clk_i, reg_addr_i, reg_wdata_i, reg_wr_i, reg_rd_i} = '0;
        rst_i = 1'b1;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_end();
        t_begin();
        t_event();
        t_dir();
        t_stop();
        t_tag();
        t_force();
        wrap_up();
    end
    // Generous bound; the tests need under two thousand cycles.
    initial begin
        #50000;
        error_cnt++;
        $display("watchdog expired");
        wrap_up();
    end
endmodule : tb_dbt_debug_top
`default_nettype wire
